// ### design/fprx_rounder.sv
// Purpose: one-step significand rounder for all four rounding modes
// Assumes: guard and sticky bits hold everything below the last place
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none

module fprx_rounder (
  input wire logic sign,
  input wire logic [23:0] sig_in,
  input wire logic guard,
  input wire logic sticky,
  input wire logic [1:0] mode,
  output logic [23:0] sig_out,
  output logic carry,
  output logic inexact
);

  logic inc;

  // ****************************************
  // choose lower or upper bracketing value
  // ****************************************
  always_comb begin
    inexact = guard | sticky;
    case (mode)
      fprx_pkg::RC_NEAR: inc = guard & (sticky | sig_in[0]);
      fprx_pkg::RC_DOWN: inc = sign & inexact;
      fprx_pkg::RC_UP: inc = ~sign & inexact;
      fprx_pkg::RC_ZERO: inc = 1'b0;
      default: inc = 1'b0;
    endcase
    {carry, sig_out} = {1'b0, sig_in} + {24'h000000, inc};
    if (carry) begin
      sig_out = 24'h800000;
    end
  end

endmodule : fprx_rounder
`default_nettype wire

// ### design/fprx_top.sv
// Purpose: rounding, exception detection and sticky flags for scalar and simd fp environments
// Assumes: core gives an unbounded-exponent result with guard and sticky bits
// Notes: one result per op_valid, answered one cycle later
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fprx_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire logic op_env,
  input wire logic [1:0] op_cls,
  input wire logic pre_invalid,
  input wire logic pre_div_zero,
  input wire logic pre_subnormal,
  input wire logic res_nan,
  input wire logic res_sign,
  input wire logic signed [9:0] res_exp,
  input wire logic [25:0] res_sig,
  output logic res_valid,
  output logic [31:0] res_data,
  output logic [5:0] res_flags,
  output logic exc_req
);

  // ****************************************
  // register state
  // ****************************************
  logic [5:0] scl_mask_r, scl_mask_nxt;
  logic [1:0] scl_rc_r, scl_rc_nxt;
  logic [5:0] scl_flag_r, scl_flag_nxt;
  logic [5:0] simd_mask_r, simd_mask_nxt;
  logic [1:0] simd_rc_r, simd_rc_nxt;
  logic [5:0] simd_flag_r, simd_flag_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic res_valid_r, res_valid_nxt;
  logic [31:0] res_data_r, res_data_nxt;
  logic [5:0] res_flags_r, res_flags_nxt;
  logic exc_req_r, exc_req_nxt;

  logic apb_wr;
  logic wr_scl_ctrl, wr_scl_stat, wr_simd;
  logic setup;
  logic mapped;

  // ****************************************
  // operation datapath signals
  // ****************************************
  logic [1:0] rc_eff;
  logic [5:0] mask_eff;
  logic exact_in;
  logic [23:0] rnd_sig;
  logic rnd_carry;
  logic rnd_inexact;
  logic signed [10:0] exp_rnd;
  logic ovf, tiny;
  logic use_max;
  logic [5:0] new_flags;
  logic [31:0] data_c;
  logic req_c;

  // ****************************************
  // apb decode
  // ****************************************
  assign setup = psel & ~penable;
  assign apb_wr = psel & penable & pready_r & pwrite;
  assign wr_scl_ctrl = apb_wr & (paddr == fprx_pkg::OFS_SCL_CTRL);
  assign wr_scl_stat = apb_wr & (paddr == fprx_pkg::OFS_SCL_STAT);
  assign wr_simd = apb_wr & (paddr == fprx_pkg::OFS_SIMD_CSR);
  assign mapped = (paddr == fprx_pkg::OFS_SCL_CTRL) | (paddr == fprx_pkg::OFS_SCL_STAT) |
                  (paddr == fprx_pkg::OFS_SIMD_CSR);

  // ****************************************
  // environment selection
  // ****************************************
  always_comb begin
    if (op_env) begin
      rc_eff = simd_rc_r;
      mask_eff = simd_mask_r;
    end else begin
      rc_eff = scl_rc_r;
      mask_eff = scl_mask_r;
    end
    if (op_cls == fprx_pkg::CLS_TRUNC) begin
      rc_eff = fprx_pkg::RC_ZERO;
    end
  end

  // compares pass through exactly, so the mode has nothing to act on
  assign exact_in = (op_cls == fprx_pkg::CLS_CMP);

  fprx_rounder u_rnd (
    .sign(res_sign),
    .sig_in(res_sig[25:2]),
    .guard(res_sig[1] & ~exact_in),
    .sticky(res_sig[0] & ~exact_in),
    .mode(rc_eff),
    .sig_out(rnd_sig),
    .carry(rnd_carry),
    .inexact(rnd_inexact)
  );

  assign exp_rnd = $signed({res_exp[9], res_exp}) + $signed({10'h000, rnd_carry});
  assign ovf = (exp_rnd >= fprx_pkg::EXP_OVF);
  assign tiny = (exp_rnd <= fprx_pkg::EXP_TINY);

  // largest finite instead of infinity when rounding points away from it
  always_comb begin
    case (rc_eff)
      fprx_pkg::RC_NEAR: use_max = 1'b0;
      fprx_pkg::RC_DOWN: use_max = ~res_sign;
      fprx_pkg::RC_UP: use_max = res_sign;
      fprx_pkg::RC_ZERO: use_max = 1'b1;
      default: use_max = 1'b0;
    endcase
  end

  // ****************************************
  // exception classification and result
  // ****************************************
  always_comb begin
    new_flags = 6'h00;
    data_c = 32'h00000000;
    new_flags[fprx_pkg::FLG_INV] = pre_invalid;
    new_flags[fprx_pkg::FLG_DZ] = pre_div_zero;
    new_flags[fprx_pkg::FLG_DEN] = pre_subnormal;
    if (|(new_flags & ~mask_eff)) begin
      data_c = 32'h00000000;
    end else if (pre_invalid) begin
      data_c = fprx_pkg::QNAN_INDEF;
    end else if (pre_div_zero) begin
      data_c = {res_sign, fprx_pkg::MAG_INF};
    end else if (res_nan) begin
      data_c = {res_sign, fprx_pkg::EXP_NAN, 1'b1, res_sig[23:2]};
    end else if (exact_in) begin
      data_c = {res_sign, res_exp[7:0], res_sig[24:2]};
    end else begin
      // subnormal masked response continues into post
      new_flags[fprx_pkg::FLG_PRE] = rnd_inexact;
      data_c = {res_sign, exp_rnd[7:0], rnd_sig[22:0]};
      if (ovf) begin
        new_flags[fprx_pkg::FLG_OVF] = 1'b1;
        if (mask_eff[fprx_pkg::FLG_OVF]) begin
          new_flags[fprx_pkg::FLG_PRE] = 1'b1;
          data_c = {res_sign, use_max ? fprx_pkg::MAG_MAXF : fprx_pkg::MAG_INF};
        end else begin
          data_c = 32'h00000000;
        end
      end else if (tiny) begin
        new_flags[fprx_pkg::FLG_UNF] = 1'b1;
        if (mask_eff[fprx_pkg::FLG_UNF]) begin
          new_flags[fprx_pkg::FLG_PRE] = 1'b1;
          data_c = {res_sign, 31'h00000000};
        end else begin
          data_c = 32'h00000000;
        end
      end
    end
    req_c = |(new_flags & ~mask_eff);
  end

  // ****************************************
  // next state of registers and outputs
  // ****************************************
  always_comb begin
    scl_mask_nxt = scl_mask_r;
    scl_rc_nxt = scl_rc_r;
    simd_mask_nxt = simd_mask_r;
    simd_rc_nxt = simd_rc_r;
    scl_flag_nxt = scl_flag_r;
    simd_flag_nxt = simd_flag_r;
    if (wr_scl_ctrl) begin
      scl_mask_nxt = pwdata[fprx_pkg::SCL_MASK_LO +: 6];
      scl_rc_nxt = pwdata[fprx_pkg::SCL_RC_LO +: 2];
    end
    if (wr_scl_stat) begin
      scl_flag_nxt = pwdata[5:0];
    end
    if (wr_simd) begin
      simd_flag_nxt = pwdata[fprx_pkg::SIMD_FLG_LO +: 6];
      simd_mask_nxt = pwdata[fprx_pkg::SIMD_MASK_LO +: 6];
      simd_rc_nxt = pwdata[fprx_pkg::SIMD_RC_LO +: 2];
    end
    // set wins over a clearing write in the same cycle
    if (op_valid & ~op_env) begin
      scl_flag_nxt = scl_flag_nxt | new_flags;
    end
    if (op_valid & op_env) begin
      simd_flag_nxt = simd_flag_nxt | new_flags;
    end
    pready_nxt = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt = 32'h00000000;
    if (setup & ~pwrite) begin
      case (paddr)
        fprx_pkg::OFS_SCL_CTRL: begin
          prdata_nxt[fprx_pkg::SCL_MASK_LO +: 6] = scl_mask_r;
          prdata_nxt[fprx_pkg::SCL_RC_LO +: 2] = scl_rc_r;
        end
        fprx_pkg::OFS_SCL_STAT: prdata_nxt[5:0] = scl_flag_r;
        fprx_pkg::OFS_SIMD_CSR: begin
          prdata_nxt[fprx_pkg::SIMD_FLG_LO +: 6] = simd_flag_r;
          prdata_nxt[fprx_pkg::SIMD_MASK_LO +: 6] = simd_mask_r;
          prdata_nxt[fprx_pkg::SIMD_RC_LO +: 2] = simd_rc_r;
        end
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    res_valid_nxt = op_valid;
    res_data_nxt = op_valid ? data_c : 32'h00000000;
    res_flags_nxt = op_valid ? new_flags : 6'h00;
    exc_req_nxt = op_valid & req_c;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_mask_r <= fprx_pkg::MASK_RST;
      scl_rc_r <= fprx_pkg::RC_NEAR;
      scl_flag_r <= fprx_pkg::FLAG_RST;
      simd_mask_r <= fprx_pkg::MASK_RST;
      simd_rc_r <= fprx_pkg::RC_NEAR;
      simd_flag_r <= fprx_pkg::FLAG_RST;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      res_valid_r <= 1'b0;
      res_data_r <= 32'h00000000;
      res_flags_r <= 6'h00;
      exc_req_r <= 1'b0;
    end else begin
      scl_mask_r <= scl_mask_nxt;
      scl_rc_r <= scl_rc_nxt;
      scl_flag_r <= scl_flag_nxt;
      simd_mask_r <= simd_mask_nxt;
      simd_rc_r <= simd_rc_nxt;
      simd_flag_r <= simd_flag_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      res_valid_r <= res_valid_nxt;
      res_data_r <= res_data_nxt;
      res_flags_r <= res_flags_nxt;
      exc_req_r <= exc_req_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign res_valid = res_valid_r;
  assign res_data = res_data_r;
  assign res_flags = res_flags_r;
  assign exc_req = exc_req_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  logic plain_arith;
  assign plain_arith = op_valid & ~pre_invalid & ~pre_div_zero & ~pre_subnormal & ~res_nan &
                       (op_cls == fprx_pkg::CLS_ARITH);

  sequence s_answer;
    ##1 res_valid_r;
  endsequence

  chk_rc_reset: assert property ($fell(srst) |->
    (scl_rc_r == fprx_pkg::RC_NEAR) && (simd_rc_r == fprx_pkg::RC_NEAR))
    else $error("rounding control not nearest after reset");

  chk_flags_sticky: assert property (!wr_scl_stat |=>
    (($past(scl_flag_r) & ~scl_flag_r) == 6'h00))
    else $error("scalar flag dropped without a write");

  chk_env_isolate: assert property ((op_valid && op_env && !wr_scl_stat) |=>
    (scl_flag_r == $past(scl_flag_r)))
    else $error("simd operation disturbed scalar flags");

  chk_precision_set: assert property ((plain_arith && (res_sig[1:0] != 2'h0) && !ovf && !tiny)
    |-> s_answer ##0 res_flags_r[fprx_pkg::FLG_PRE])
    else $error("inexact result without precision flag");

  chk_cmp_exact: assert property ((op_valid && exact_in && !res_nan &&
    !pre_invalid && !pre_div_zero && !pre_subnormal)
    |-> s_answer ##0 (res_flags_r == 6'h00) ##0 (res_data_r[22:0] == $past(res_sig[24:2])))
    else $error("compare was rounded or flagged");

  chk_masked_inv: assert property ((op_valid && pre_invalid && mask_eff == 6'h3f)
    |=> (res_data_r == fprx_pkg::QNAN_INDEF) && !exc_req_r)
    else $error("masked invalid did not give indefinite");

  chk_unmasked_req: assert property ((op_valid && pre_invalid && !mask_eff[fprx_pkg::FLG_INV])
    |=> exc_req_r && res_flags_r[fprx_pkg::FLG_INV])
    else $error("unmasked invalid gave no handler request");

  chk_trunc_zero: assert property ((op_valid && op_cls == fprx_pkg::CLS_TRUNC && !res_nan &&
    !pre_invalid && !pre_div_zero && !pre_subnormal && !ovf && !tiny)
    |=> res_data_r[22:0] == $past(res_sig[24:2]))
    else $error("truncating convert did not round toward zero");

  chk_tie_even: assert property ((plain_arith && rc_eff == fprx_pkg::RC_NEAR && res_sig[2:0] == 3'h2 &&
    !ovf && !tiny) |=> res_data_r[22:0] == $past(res_sig[24:2]))
    else $error("tie did not round to even");

  chk_ovf_masked: assert property ((plain_arith && ovf && mask_eff[fprx_pkg::FLG_OVF] &&
    rc_eff == fprx_pkg::RC_ZERO) |=> res_data_r[30:0] == fprx_pkg::MAG_MAXF &&
    res_flags_r[fprx_pkg::FLG_OVF])
    else $error("masked overflow under truncation not largest finite");

  chk_apb_answer: assert property ((psel && !penable) |=> pready_r)
    else $error("apb access phase not answered at once");

endmodule : fprx_top
`default_nettype wire

// ### pkg/fprx_pkg.sv
// Purpose: constants for the fp rounding and exception-flag block
// Assumes: single-precision result path, apb register access
// Notes: flag and mask bit order is shared by both environments
//
// Contract
// - pick one of the two bracketing representable values, error under one ulp
// - mode 00b rounds to nearest, ties go to the even value
// - mode 01b rounds toward negative infinity
// - mode 10b rounds toward positive infinity
// - mode 11b truncates toward zero
// - both rounding control fields reset to round to nearest even
// - any rounded result differing from precise sets that environment's precision flag
// - rounding mode ignored for compares, exact results and nan results
// - scalar unit rounding mode sits in control word bits 10 and 11
// - simd unit rounding mode sits in its control/status bits 13 and 14
// - truncating float to integer converts always round toward zero
// - six exception classes are detected
// - invalid, divide-by-zero, subnormal before arithmetic; others after rounding
// - a detected condition sets its flag; masked gives a default result
// - an unmasked detected condition sets its flag and requests the handler
// - exception flags are sticky and accumulate
// - scalar flags in status bits 0..5, masks in control bits 0..5
// - simd flags in bits 0..5, masks in bits 7..12
// - scalar and simd flag and mask sets never affect each other
// - masked responses continue, so one operation may set several flags
// - masked overflow returns infinity or largest finite per rounding mode
// - masked invalid returns the indefinite quiet nan
`default_nettype none

package fprx_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_SCL_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCL_STAT = 8'h04;
  localparam logic [7:0] OFS_SIMD_CSR = 8'h08;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FLG_INV = 0;
  localparam int FLG_DEN = 1;
  localparam int FLG_DZ = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_UNF = 4;
  localparam int FLG_PRE = 5;
  localparam int SCL_MASK_LO = 0;
  localparam int SCL_RC_LO = 10;
  localparam int SIMD_FLG_LO = 0;
  localparam int SIMD_MASK_LO = 7;
  localparam int SIMD_RC_LO = 13;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] MASK_RST = 6'h3f;
  localparam logic [5:0] FLAG_RST = 6'h00;

  // ****************************************
  // rounding modes and operation classes
  // ****************************************
  localparam logic [1:0] RC_NEAR = 2'h0;
  localparam logic [1:0] RC_DOWN = 2'h1;
  localparam logic [1:0] RC_UP = 2'h2;
  localparam logic [1:0] RC_ZERO = 2'h3;
  localparam logic [1:0] CLS_ARITH = 2'h0;
  localparam logic [1:0] CLS_CMP = 2'h1;
  localparam logic [1:0] CLS_TRUNC = 2'h2;

  // ****************************************
  // single-precision encodings
  // ****************************************
  localparam logic signed [10:0] EXP_OVF = 11'sh0ff;
  localparam logic signed [10:0] EXP_TINY = 11'sh000;
  localparam logic [30:0] MAG_INF = 31'h7f800000;
  localparam logic [30:0] MAG_MAXF = 31'h7f7fffff;
  localparam logic [31:0] QNAN_INDEF = 32'hffc00000;
  localparam logic [7:0] EXP_NAN = 8'hff;

endpackage : fprx_pkg
`default_nettype wire

// ### verification/fp_rounding_exception_flags_tb_top.sv
// Purpose: self-checking bench for rounding and sticky exception flags
// Assumes: no apb wait states, pready high in the first access cycle, results one cycle after the request
// Notes: expectations come from the rounding modes and masked responses
`timescale 1ns/1ps
`default_nettype none

module fp_rounding_exception_flags_tb_top;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, res_valid, exc_req, op_valid, op_env;
  logic pre_invalid, pre_div_zero, pre_subnormal, res_nan, res_sign, r_exc, rerr, lost;
  logic [1:0] op_cls, md;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, res_data, r_data, rdv;
  logic [5:0] res_flags, r_flags;
  logic signed [9:0] res_exp;
  logic [25:0] res_sig;
  logic [23:0] s24;
  int mismatches = 0;
  int compares = 0;

  fprx_top uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_env(op_env), .op_cls(op_cls), .pre_invalid(pre_invalid),
    .pre_div_zero(pre_div_zero), .pre_subnormal(pre_subnormal), .res_nan(res_nan),
    .res_sign(res_sign), .res_exp(res_exp), .res_sig(res_sig), .res_valid(res_valid),
    .res_data(res_data), .res_flags(res_flags), .exc_req(exc_req));
  fprx_core_model u_core (.mclk(mclk), .op_valid(op_valid), .op_env(op_env), .op_cls(op_cls),
    .pre_invalid(pre_invalid), .pre_div_zero(pre_div_zero), .pre_subnormal(pre_subnormal),
    .res_nan(res_nan), .res_sign(res_sign), .res_exp(res_exp), .res_sig(res_sig),
    .res_valid(res_valid), .res_data(res_data), .res_flags(res_flags), .exc_req(exc_req));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // request held until the edge at which pready is sampled high
    for (n = 0; n < 8; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        break;
      end
    end
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic op(input logic env, input logic [1:0] cls, input logic [2:0] pre, input logic nan,
    input logic sg, input logic [9:0] e, input logic [25:0] sig);
    u_core.issue(env, cls, pre, nan, sg, e, sig, r_data, r_flags, r_exc, lost);
    if (lost) begin
      mismatches++;
      end_of_test();
    end
  endtask : op

  function automatic logic [31:0] rnd_exp(logic sg, logic [23:0] sig, logic g, logic s, logic [1:0] m);
    logic up;
    logic [24:0] sum;
    up = (m == 2'h0) ? (g & (s | sig[0])) : (m == 2'h1) ? (sg & (g | s)) : (m == 2'h2) ? (~sg & (g | s)) : 1'b0;
    sum = {1'b0, sig} + 25'(up);
    return {sg, 8'h7f, sum[22:0]};
  endfunction : rnd_exp

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, fprx_pkg::OFS_SCL_CTRL, 32'h0);
    check(rdv, 32'h3f);
    apb(1'b0, fprx_pkg::OFS_SIMD_CSR, 32'h0);
    check(rdv, 32'h1f80);
    apb(1'b1, 8'h0c, 32'hffff);
    check(rerr, 1'b1);
    $display("test reset_values done");
    for (int env = 0; env < 2; env++) begin
      apb(1'b1, fprx_pkg::OFS_SCL_STAT, 32'h0);
      for (int m = 0; m < 4; m++) begin
        md = 2'(m);
        apb(1'b1, fprx_pkg::OFS_SCL_CTRL, 32'h3f | (32'(env ? ~md : md) << 10));
        apb(1'b1, fprx_pkg::OFS_SIMD_CSR, 32'h1f80 | (32'(env ? md : ~md) << 13));
        for (int k = 0; k < 16; k++) begin
          s24 = {1'b1, 22'h0, k[2]};
          op(env[0], 2'h0, 3'h0, 1'b0, k[3], 10'h07f, {s24, k[1:0]});
          check(r_data, rnd_exp(k[3], s24, k[1], k[0], md));
          check(r_flags, {(k[1] | k[0]), 5'h0});
          check(r_exc, 1'b0);
        end
      end
    end
    apb(1'b0, fprx_pkg::OFS_SCL_STAT, 32'h0);
    check(rdv, 32'h0);
    apb(1'b0, fprx_pkg::OFS_SIMD_CSR, 32'h0);
    check(rdv, 32'h7fa0);
    $display("test rounding_modes done");
    apb(1'b1, fprx_pkg::OFS_SCL_CTRL, 32'h3f);
    op(1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 10'h07f, {24'hffffff, 2'b11});
    check(r_data, 32'h40000000);
    op(1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 10'h07f, {24'hc00000, 2'b00});
    check(r_flags, 6'h00);
    apb(1'b0, fprx_pkg::OFS_SCL_STAT, 32'h0);
    check(rdv, 32'h20);
    apb(1'b1, fprx_pkg::OFS_SCL_STAT, 32'h0);
    apb(1'b0, fprx_pkg::OFS_SCL_STAT, 32'h0);
    check(rdv, 32'h0);
    apb(1'b1, fprx_pkg::OFS_SCL_CTRL, 32'h83f);
    op(1'b0, 2'h1, 3'h0, 1'b0, 1'b0, 10'h07f, {24'hc00001, 2'b11});
    check(r_data, 32'h3fc00001);
    op(1'b0, 2'h0, 3'h0, 1'b1, 1'b1, 10'h0ff, {24'h012345, 2'b11});
    check(r_data, 32'hffc12345);
    for (int sg = 0; sg < 2; sg++) begin
      op(1'b0, 2'h2, 3'h0, 1'b0, sg[0], 10'h07f, {24'hc00001, 2'b11});
      check(r_data, {sg[0], 31'h3fc00001});
    end
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, fprx_pkg::OFS_SCL_CTRL, 32'h3f | (32'(m[1:0]) << 10));
      op(1'b0, 2'h0, 3'h0, 1'b0, m[2], 10'h0ff, {24'h800000, 2'b00});
      md = m[1:0];
      check(r_data, {m[2], (md == 2'h0 || (md == 2'h1 && m[2]) || (md == 2'h2 && !m[2])) ?
        fprx_pkg::MAG_INF : fprx_pkg::MAG_MAXF});
      check(r_flags, 6'h28);
    end
    $display("test special_results done");
    apb(1'b1, fprx_pkg::OFS_SCL_CTRL, 32'h3f);
    op(1'b0, 2'h0, 3'b100, 1'b0, 1'b0, 10'h07f, {24'h800000, 2'b00});
    check(r_data, fprx_pkg::QNAN_INDEF);
    check(r_flags, 6'h01);
    op(1'b0, 2'h0, 3'b010, 1'b0, 1'b1, 10'h07f, {24'h800000, 2'b00});
    check(r_data, {1'b1, fprx_pkg::MAG_INF});
    check(r_flags, 6'h04);
    op(1'b0, 2'h0, 3'b001, 1'b0, 1'b0, 10'h000, {24'h800000, 2'b00});
    check(r_data, 32'h0);
    check(r_flags, 6'h32);
    apb(1'b1, fprx_pkg::OFS_SCL_CTRL, 32'h0);
    op(1'b0, 2'h0, 3'b100, 1'b0, 1'b0, 10'h0ff, {24'h800000, 2'b11});
    check(r_data, 32'h0);
    check(r_flags, 6'h01);
    check(r_exc, 1'b1);
    op(1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 10'h0ff, {24'h800000, 2'b00});
    check(r_data, 32'h0);
    check(r_flags, 6'h08);
    check(r_exc, 1'b1);
    apb(1'b1, fprx_pkg::OFS_SIMD_CSR, 32'h1f00);
    op(1'b1, 2'h0, 3'b100, 1'b0, 1'b0, 10'h07f, {24'h800000, 2'b00});
    check(r_exc, 1'b1);
    op(1'b1, 2'h0, 3'b010, 1'b0, 1'b0, 10'h07f, {24'h800000, 2'b00});
    check(r_exc, 1'b0);
    apb(1'b0, fprx_pkg::OFS_SIMD_CSR, 32'h0);
    check(rdv, 32'h1f05);
    $display("test masks_and_handler done");
    end_of_test();
  end
endmodule : fp_rounding_exception_flags_tb_top
`default_nettype wire

// ### verification/fprx_core_model.sv
// Purpose: execution core model that hands one precise result at a time to the block
// Assumes: the answer comes the cycle after the request edge
// Notes: pre flags, res_exp and res_sig are inverted once a request is taken, so stale values never help
`timescale 1ns/1ps
`default_nettype none

module fprx_core_model (
  input wire logic mclk,
  output logic op_valid,
  output logic op_env,
  output logic [1:0] op_cls,
  output logic pre_invalid,
  output logic pre_div_zero,
  output logic pre_subnormal,
  output logic res_nan,
  output logic res_sign,
  output logic signed [9:0] res_exp,
  output logic [25:0] res_sig,
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  input wire logic [5:0] res_flags,
  input wire logic exc_req
);
  initial begin
    {op_valid, op_env, op_cls, pre_invalid, pre_div_zero, pre_subnormal, res_nan, res_sign} = '0;
    res_exp = '0;
    res_sig = '0;
  end

  // pre holds invalid, divide-by-zero, subnormal from high to low
  task automatic issue(input logic env, input logic [1:0] cls, input logic [2:0] pre, input logic nan,
    input logic sg, input logic [9:0] e, input logic [25:0] sig, output logic [31:0] data,
    output logic [5:0] flags, output logic exc, output logic lost);
    int n;
    lost = 1'b1;
    data = '0;
    flags = '0;
    exc = 1'b0;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_env <= env;
    op_cls <= cls;
    {pre_invalid, pre_div_zero, pre_subnormal} <= pre;
    res_nan <= nan;
    res_sign <= sg;
    res_exp <= e;
    res_sig <= sig;
    @(posedge mclk);
    op_valid <= 1'b0;
    {pre_invalid, pre_div_zero, pre_subnormal} <= ~pre;
    res_exp <= ~e;
    res_sig <= ~sig;
    // result is taken at the edge where res_valid is sampled high
    for (n = 0; n < 4 && lost; n++) begin
      @(posedge mclk);
      if (res_valid === 1'b1) begin
        data = res_data;
        flags = res_flags;
        exc = exc_req;
        lost = 1'b0;
      end
    end
  endtask : issue
endmodule : fprx_core_model
`default_nettype wire
